// ==== design/omdsf_top.sv ====
// Diagnostic status, control and flag registers behind an APB slave.

// Operation
// RQ1 - Customer bytes 128 to 247 accept and keep every host write.
// RQ2 - Status bit 7 reads the synchronised transmit-off pin level.
// RQ3 - Status bit 6 is a host read/write software transmit-off.
// RQ4 - Transmitter is off when software bit or pin asks for it.
// RQ5 - Status bit 4 reads the bandwidth-select pin level.
// RQ6 - Bandwidth-select pin is ignored; full bandwidth always.
// RQ7 - Status bit 2 reads back the transmitter-fault output.
// RQ8 - Status bit 1 reads back the signal-loss output.
// RQ9 - Status bit 0 reads 1 until monitored values are valid.
// RQ10 - Alarm byte one: temp, supply, bias, transmit power high/low.
// RQ11 - Alarm byte two: receive power high bit 7, low bit 6.
// RQ12 - Warning byte one uses the alarm byte one layout.
// RQ13 - Warning byte two bit 7 flags receive power above high warning.
// RQ14 - Receive power low warning sits at bit 6 of warning byte two.
// RQ15 - Low flags set below low threshold, high flags above high.
// RQ16 - Status bits 5 and 3 read zero and ignore writes.
// RQ17 - Temperature compares as signed 16-bit values.
// RQ18 - Legacy byte 127 takes writes without error and does nothing.
module omdsf_top #(
    parameter int NUM_THRESH = omdsf_pkg::NUM_THRESH,
    parameter int USER_DEPTH = omdsf_pkg::USER_DEPTH
) (
    // Clock and reset.
    input  wire logic        MCLK,
    input  wire logic        RST,
    // APB slave.
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Module pins from the host side.
    input  wire logic        TX_OFF_PIN,
    input  wire logic        RATE_SEL_PIN,
    // Conditions from the optics.
    input  wire logic        LASER_FAULT_IN,
    input  wire logic        RX_SIGNAL_LOST_IN,
    // Monitored values from the sensing logic, same clock.
    input  wire logic        VALUES_READY,
    input  wire logic [15:0] TEMP_VALUE,
    input  wire logic [15:0] SUPPLY_VALUE,
    input  wire logic [15:0] BIAS_VALUE,
    input  wire logic [15:0] TX_POWER_VALUE,
    input  wire logic [15:0] RX_POWER_VALUE,
    // Controls and module outputs.
    output logic             TX_OFF,
    output logic             FULL_BW,
    output logic             TX_FAULT,
    output logic             SIGNAL_LOSS,
    output logic             IRQ
);

    // Pin synchronisers, two stages each.
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    wire logic  tx_off_pin_s = pin_sync[3];
    wire logic  rate_sel_s   = pin_sync[2];
    wire logic  fault_s      = pin_sync[1];
    wire logic  loss_s       = pin_sync[0];

    // Register state.
    logic [15:0] thresh [NUM_THRESH];
    logic        soft_tx_off;
    logic [7:0]  alarm_low;
    logic [7:0]  alarm_rx;
    logic [7:0]  warn_low;
    logic [7:0]  warn_rx;
    logic [19:0] flags_prev;
    logic [19:0] irq_status;
    logic [19:0] irq_mask;

    // Bus decode.
    logic        addr_ok;
    logic [8:0]  idx;
    logic        access;
    logic        wr_fire;
    logic        is_thresh;
    logic        is_user;
    logic        known;
    logic [6:0]  user_addr;
    logic [7:0]  user_rdata;
    logic [31:0] next_rdata;
    logic [7:0]  status_byte;

    // Comparison results.
    logic [15:0] qty [omdsf_pkg::NUM_QTY];
    logic [omdsf_pkg::NUM_QTY-1:0] hi_alarm;
    logic [omdsf_pkg::NUM_QTY-1:0] lo_alarm;
    logic [omdsf_pkg::NUM_QTY-1:0] hi_warn;
    logic [omdsf_pkg::NUM_QTY-1:0] lo_warn;
    logic [7:0]  next_alarm_low;
    logic [7:0]  next_alarm_rx;
    logic [7:0]  next_warn_low;
    logic [7:0]  next_warn_rx;
    logic [19:0] flags_now;
    logic [19:0] events;

    // Pins from outside the clock domain pass two flip-flops.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end else begin
            pin_meta <= {TX_OFF_PIN, RATE_SEL_PIN,
                         LASER_FAULT_IN, RX_SIGNAL_LOST_IN};
            pin_sync <= pin_meta;
        end
    end

    // Address decode: word aligned, index in bits 10 to 2.
    assign addr_ok   = (PADDR[1:0] == 2'b00) && !PADDR[11];
    assign idx       = PADDR[10:2];
    assign access    = PSEL && PENABLE;
    assign wr_fire   = access && PREADY && PWRITE;
    assign is_thresh = addr_ok && (idx <= omdsf_pkg::IDX_THRESH_LAST);
    assign is_user   = addr_ok && (idx >= omdsf_pkg::IDX_USER_FIRST)
                       && (idx <= omdsf_pkg::IDX_USER_LAST);
    assign user_addr = 7'(idx - omdsf_pkg::IDX_USER_FIRST);

    // Valid addresses; anything else answers with an error.
    always_comb begin
        known = is_thresh || is_user;
        if (addr_ok) begin
            unique case (idx)
                omdsf_pkg::IDX_STATUS_CTRL,
                omdsf_pkg::IDX_ALARM_LOW,
                omdsf_pkg::IDX_ALARM_RX,
                omdsf_pkg::IDX_WARN_LOW,
                omdsf_pkg::IDX_WARN_RX,
                omdsf_pkg::IDX_LEGACY, // RQ18
                omdsf_pkg::IDX_IRQ_STATUS,
                omdsf_pkg::IDX_IRQ_MASK: known = 1'b1;
                default: ;
            endcase
        end
    end

    // One wait state: ready rises in the second access cycle.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            PREADY <= 1'b0;
        end else begin
            PREADY <= access && !PREADY;
        end
    end

    // Read data and error are captured as ready rises.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PRDATA  <= (access && !PREADY && !PWRITE) ? next_rdata
                       : 32'h0000_0000;
            PSLVERR <= access && !PREADY && !known;
        end
    end

    // Status/control byte; reserved bits 5 and 3 are constant zero.
    always_comb begin
        status_byte = 8'h00; // RQ16
        status_byte[omdsf_pkg::BIT_TX_OFF_STATE] = tx_off_pin_s; // RQ2
        status_byte[omdsf_pkg::BIT_SOFT_TX_OFF]  = soft_tx_off; // RQ3
        status_byte[omdsf_pkg::BIT_RATE_STATE]   = rate_sel_s; // RQ5
        status_byte[omdsf_pkg::BIT_FAULT_STATE]  = TX_FAULT; // RQ7
        status_byte[omdsf_pkg::BIT_LOSS_STATE]   = SIGNAL_LOSS; // RQ8
        status_byte[omdsf_pkg::BIT_NOT_READY]    = !VALUES_READY; // RQ9
    end

    // Read multiplexer, narrow data in the low bits.
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (is_thresh) begin
            next_rdata = {16'h0000, thresh[idx[4:0]]};
        end else if (is_user) begin
            next_rdata = {24'h00_0000, user_rdata}; // RQ1
        end else if (addr_ok) begin
            unique case (idx)
                omdsf_pkg::IDX_STATUS_CTRL:
                    next_rdata = {24'h00_0000, status_byte};
                omdsf_pkg::IDX_ALARM_LOW:
                    next_rdata = {24'h00_0000, alarm_low}; // RQ10
                omdsf_pkg::IDX_ALARM_RX:
                    next_rdata = {24'h00_0000, alarm_rx}; // RQ11
                omdsf_pkg::IDX_WARN_LOW:
                    next_rdata = {24'h00_0000, warn_low}; // RQ12
                omdsf_pkg::IDX_WARN_RX:
                    next_rdata = {24'h00_0000, warn_rx}; // RQ13
                omdsf_pkg::IDX_IRQ_STATUS:
                    next_rdata = {12'h000, irq_status};
                omdsf_pkg::IDX_IRQ_MASK:
                    next_rdata = {12'h000, irq_mask};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // Threshold words written by the host.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < NUM_THRESH; i++) begin
                thresh[i] <= omdsf_pkg::THRESH_RESET;
            end
        end else if (wr_fire && is_thresh) begin
            thresh[idx[4:0]] <= PWDATA[15:0];
        end
    end

    // Software transmit-off; other bits of the byte ignore writes.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            soft_tx_off <= 1'b0;
        end else if (wr_fire && addr_ok
                     && (idx == omdsf_pkg::IDX_STATUS_CTRL)) begin
            soft_tx_off <= PWDATA[omdsf_pkg::BIT_SOFT_TX_OFF]; // RQ3
        end
    end

    // Customer-writable bytes.
    omdsf_user_mem #(
        .DEPTH (USER_DEPTH),
        .AW    (omdsf_pkg::USER_AW),
        .INIT  (omdsf_pkg::USER_RESET)
    ) u_user_mem (
        .clk     (MCLK),
        .rst     (RST),
        .wr_en   (wr_fire && is_user), // RQ1
        .wr_addr (user_addr),
        .wr_data (PWDATA[7:0]),
        .rd_addr (user_addr),
        .rd_data (user_rdata)
    );

    // Module outputs driven from flip-flops.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            TX_OFF      <= 1'b1;
            FULL_BW     <= 1'b1;
            TX_FAULT    <= 1'b0;
            SIGNAL_LOSS <= 1'b0;
        end else begin
            TX_OFF      <= soft_tx_off || tx_off_pin_s; // RQ4
            FULL_BW     <= 1'b1; // RQ6
            TX_FAULT    <= fault_s;
            SIGNAL_LOSS <= loss_s;
        end
    end

    // Quantities in slot order: temp, supply, bias, tx and rx power.
    assign qty[0] = TEMP_VALUE;
    assign qty[1] = SUPPLY_VALUE;
    assign qty[2] = BIAS_VALUE;
    assign qty[3] = TX_POWER_VALUE;
    assign qty[4] = RX_POWER_VALUE;

    // One comparator set per quantity; temperature is signed.
    for (genvar q = 0; q < omdsf_pkg::NUM_QTY; q++) begin : g_cmp
        localparam int B = 4 * q;
        logic signed [16:0] v;
        logic signed [16:0] th_ha;
        logic signed [16:0] th_la;
        logic signed [16:0] th_hw;
        logic signed [16:0] th_lw;
        // Extend to 17 bits, sign or zero by quantity.
        localparam bit sx = (q == 0); // RQ17
        assign v     = {sx & qty[q][15], qty[q]};
        assign th_ha = {sx & thresh[B + omdsf_pkg::SLOT_HI_ALARM][15],
                        thresh[B + omdsf_pkg::SLOT_HI_ALARM]};
        assign th_la = {sx & thresh[B + omdsf_pkg::SLOT_LO_ALARM][15],
                        thresh[B + omdsf_pkg::SLOT_LO_ALARM]};
        assign th_hw = {sx & thresh[B + omdsf_pkg::SLOT_HI_WARN][15],
                        thresh[B + omdsf_pkg::SLOT_HI_WARN]};
        assign th_lw = {sx & thresh[B + omdsf_pkg::SLOT_LO_WARN][15],
                        thresh[B + omdsf_pkg::SLOT_LO_WARN]};
        // High flags above the high limit, low flags below the low one.
        assign hi_alarm[q] = v > th_ha; // RQ15
        assign lo_alarm[q] = v < th_la; // RQ15
        assign hi_warn[q]  = v > th_hw; // RQ15
        assign lo_warn[q]  = v < th_lw; // RQ15
    end

    // Flag bytes assembled from comparisons; held at zero until values ready.
    always_comb begin
        next_alarm_low = 8'h00;
        next_warn_low  = 8'h00;
        next_alarm_rx  = 8'h00;
        next_warn_rx   = 8'h00;
        if (VALUES_READY) begin
            for (int q = 0; q < 4; q++) begin
                next_alarm_low[7 - 2*q] = hi_alarm[q]; // RQ10
                next_alarm_low[6 - 2*q] = lo_alarm[q]; // RQ10
                next_warn_low[7 - 2*q]  = hi_warn[q]; // RQ12
                next_warn_low[6 - 2*q]  = lo_warn[q]; // RQ12
            end
            next_alarm_rx[omdsf_pkg::BIT_RX_HIGH] = hi_alarm[4]; // RQ11
            next_alarm_rx[omdsf_pkg::BIT_RX_LOW]  = lo_alarm[4]; // RQ11
            next_warn_rx[omdsf_pkg::BIT_RX_HIGH]  = hi_warn[4]; // RQ13
            next_warn_rx[omdsf_pkg::BIT_RX_LOW]   = lo_warn[4]; // RQ14
        end
    end

    // Flag registers track the comparisons every clock.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            alarm_low <= 8'h00;
            alarm_rx  <= 8'h00;
            warn_low  <= 8'h00;
            warn_rx   <= 8'h00;
        end else begin
            alarm_low <= next_alarm_low;
            alarm_rx  <= next_alarm_rx;
            warn_low  <= next_warn_low;
            warn_rx   <= next_warn_rx;
        end
    end

    // Event vector: a flag that rises raises its status bit.
    assign flags_now = {warn_rx[7:6], warn_low, alarm_rx[7:6], alarm_low};
    assign events    = flags_now & ~flags_prev;

    // Previous flags for edge detection.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            flags_prev <= 20'h0_0000;
        end else begin
            flags_prev <= flags_now;
        end
    end

    // Sticky status, write one to clear; a new event wins over a clear.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            irq_status <= 20'h0_0000;
        end else if (wr_fire && addr_ok
                     && (idx == omdsf_pkg::IDX_IRQ_STATUS)) begin
            irq_status <= (irq_status & ~PWDATA[19:0]) | events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    // Interrupt mask, one enables the matching status bit.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            irq_mask <= omdsf_pkg::MASK_RESET;
        end else if (wr_fire && addr_ok
                     && (idx == omdsf_pkg::IDX_IRQ_MASK)) begin
            irq_mask <= PWDATA[19:0];
        end
    end

    // Level interrupt while any unmasked status bit is set.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_status & irq_mask);
        end
    end

endmodule

// ==== design/omdsf_pkg.sv ====
// Package with register map, field positions and reset values.
package omdsf_pkg;

    // Register indices; the byte address on APB is four times the index.
    localparam logic [8:0] IDX_THRESH_FIRST = 9'h000;
    localparam logic [8:0] IDX_THRESH_LAST  = 9'h013;
    localparam logic [8:0] IDX_STATUS_CTRL  = 9'h06e;
    localparam logic [8:0] IDX_ALARM_LOW    = 9'h070;
    localparam logic [8:0] IDX_ALARM_RX     = 9'h071;
    localparam logic [8:0] IDX_WARN_LOW     = 9'h074;
    localparam logic [8:0] IDX_WARN_RX      = 9'h075;
    localparam logic [8:0] IDX_LEGACY       = 9'h07f;
    localparam logic [8:0] IDX_USER_FIRST   = 9'h080;
    localparam logic [8:0] IDX_USER_LAST    = 9'h0f7;
    localparam logic [8:0] IDX_IRQ_STATUS   = 9'h100;
    localparam logic [8:0] IDX_IRQ_MASK     = 9'h101;

    // Field positions in the status/control byte.
    localparam int BIT_TX_OFF_STATE = 7;
    localparam int BIT_SOFT_TX_OFF  = 6;
    localparam int BIT_RATE_STATE   = 4;
    localparam int BIT_FAULT_STATE  = 2;
    localparam int BIT_LOSS_STATE   = 1;
    localparam int BIT_NOT_READY    = 0;

    // Flag bit positions of the receive power bytes.
    localparam int BIT_RX_HIGH = 7;
    localparam int BIT_RX_LOW  = 6;

    // Sizes.
    localparam int NUM_QTY      = 5;
    localparam int NUM_THRESH   = 20;
    localparam int USER_DEPTH   = 120;
    localparam int USER_AW      = 7;
    localparam int NUM_EVENTS   = 20;

    // Threshold slot order per quantity.
    localparam int SLOT_HI_ALARM = 0;
    localparam int SLOT_LO_ALARM = 1;
    localparam int SLOT_HI_WARN  = 2;
    localparam int SLOT_LO_WARN  = 3;

    // Reset values.
    localparam logic [15:0] THRESH_RESET = 16'h0000;
    localparam logic [19:0] MASK_RESET   = 20'h0_0000;
    localparam logic [7:0]  USER_RESET   = 8'h00;

endpackage

// ==== design/omdsf_user_mem.sv ====
// Small byte memory for the customer-writable range, registered read.
module omdsf_user_mem #(
    parameter int          DEPTH = 120,
    parameter int          AW    = 7,
    parameter logic [7:0]  INIT  = 8'h00
) (
    // Clock and reset.
    input  wire logic          clk,
    input  wire logic          rst,
    // Write port.
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data,
    // Read port.
    input  wire logic [AW-1:0] rd_addr,
    output logic      [7:0]    rd_data
);

    logic [7:0] mem [DEPTH];

    // Storage cleared at reset so every byte reads a defined value.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= INIT;
            end
        end else if (wr_en && (int'(wr_addr) < DEPTH)) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read data comes out of a register one clock after the address.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= INIT;
        end else if (int'(rd_addr) < DEPTH) begin
            rd_data <= mem[rd_addr];
        end else begin
            rd_data <= INIT;
        end
    end

endmodule

// ==== tb/omdsf_sense_model.sv ====
// Model of the sensing and optics side that feeds the flag block.
module omdsf_sense_model (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    // Commands from the bench.
    input  wire logic        ready_cmd,
    input  wire logic        fault_cmd,
    input  wire logic        loss_cmd,
    input  wire logic [2:0]  sel,
    input  wire logic [15:0] level,
    // Conditions and values towards the block.
    output logic             values_ready,
    output logic             laser_fault,
    output logic             signal_lost,
    output logic [15:0]      value [5]
);
    localparam logic [15:0] BASE = 16'h0400;

    // Conditions stay quiet in reset so no pin is seen mid-reset.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            values_ready <= 1'b0;
            laser_fault  <= 1'b0;
            signal_lost  <= 1'b0;
        end else begin
            values_ready <= ready_cmd;
            laser_fault  <= fault_cmd;
            signal_lost  <= loss_cmd;
        end
    end

    // One quantity at a time leaves the quiet baseline.
    always_ff @(posedge clk or posedge rst) begin
        for (int q = 0; q < 5; q++) begin
            if (rst) value[q] <= BASE;
            else value[q] <= (sel == 3'(q)) ? level : BASE;
        end
    end
endmodule

// ==== tb/omdsf_top_assertions.sv ====
// Checker of port timing for the diagnostic flag block.
module omdsf_top_assertions (
    // Clock and reset.
    input  wire logic        MCLK,
    input  wire logic        RST,
    // APB.
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic [11:0] PADDR,
    input  wire logic        PWRITE,
    input  wire logic [31:0] PRDATA,
    input  wire logic        PREADY,
    input  wire logic        PSLVERR,
    // Pins and outputs.
    input  wire logic        TX_OFF_PIN,
    input  wire logic        RATE_SEL_PIN,
    input  wire logic        LASER_FAULT_IN,
    input  wire logic        RX_SIGNAL_LOST_IN,
    input  wire logic        TX_OFF,
    input  wire logic        FULL_BW,
    input  wire logic        TX_FAULT,
    input  wire logic        SIGNAL_LOSS
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    tx_pin_off_a: assert property (TX_OFF_PIN [*4] |-> TX_OFF)
        else $error("transmitter on while off pin held");
    full_bw_a: assert property ($changed(RATE_SEL_PIN) |=> FULL_BW [*3])
        else $error("bandwidth followed select pin");
    fault_follow_a: assert property ((LASER_FAULT_IN [*4] |-> TX_FAULT)
        and (!LASER_FAULT_IN [*4] |-> !TX_FAULT))
        else $error("fault output does not follow fault");
    loss_rise_a: assert property ($rose(RX_SIGNAL_LOST_IN) ##1
        RX_SIGNAL_LOST_IN [*2] |=> SIGNAL_LOSS)
        else $error("signal loss output late");
    status_resv_a: assert property (PREADY && !PWRITE &&
        PADDR == 12'h1b8 |-> PRDATA[5] == 1'b0 && PRDATA[3] == 1'b0)
        else $error("reserved status bits set");
    pready_one_a: assert property (PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");
    pready_wait_a: assert property ($rose(PENABLE) && PSEL |->
        !PREADY ##1 PREADY) else $error("ready not after one wait");
    ready_access_a: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside access phase");
    err_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    err_align_a: assert property (PSEL && PENABLE && PREADY &&
        (PADDR[1:0] != 2'b00 || PADDR[11]) |-> PSLVERR)
        else $error("misaligned access not refused");
    rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
        else $error("read data outside ready cycle");
endmodule

bind omdsf_top omdsf_top_assertions chk (
    .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PADDR(PADDR), .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TX_OFF_PIN(TX_OFF_PIN),
    .RATE_SEL_PIN(RATE_SEL_PIN), .LASER_FAULT_IN(LASER_FAULT_IN),
    .RX_SIGNAL_LOST_IN(RX_SIGNAL_LOST_IN), .TX_OFF(TX_OFF),
    .FULL_BW(FULL_BW), .TX_FAULT(TX_FAULT), .SIGNAL_LOSS(SIGNAL_LOSS)
);

// ==== tb/omdsf_top_test.sv ====
// Self-checking bench for the diagnostic status and flag registers.
module omdsf_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [2:0]  sel;
        logic [15:0] lvl;
        logic [31:0] flags;
    } omdsf_row_type;
    logic        MCLK, RST, PSEL, PENABLE, PWRITE, TX_OFF_PIN, RATE_SEL_PIN;
    logic        PREADY, PSLVERR, TX_OFF, FULL_BW, TX_FAULT, SIGNAL_LOSS, IRQ;
    logic        VALUES_READY, LASER_FAULT_IN, RX_SIGNAL_LOST_IN, err;
    logic        ready_cmd, fault_cmd, loss_cmd;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd, f;
    logic [2:0]  sel;
    logic [15:0] level;
    logic [15:0] vals [5];
    int          fails = 0;
    int          n_tests = 0;
    // Rows: quantity, level, expected {alarm, alarm rx, warn, warn rx}.
    omdsf_row_type rows [13] = '{
        '{3'd0, 16'h2000, 32'h8000_8000}, '{3'd0, 16'hfe00, 32'h4000_4000},
        '{3'd0, 16'hff40, 32'h0000_4000}, '{3'd0, 16'h1000, 32'h0000_8000},
        '{3'd1, 16'h2000, 32'h2000_2000}, '{3'd1, 16'h0080, 32'h1000_1000},
        '{3'd2, 16'h2000, 32'h0800_0800}, '{3'd2, 16'h0080, 32'h0400_0400},
        '{3'd3, 16'h2000, 32'h0200_0200}, '{3'd3, 16'h0080, 32'h0100_0100},
        '{3'd4, 16'h2000, 32'h0080_0080}, '{3'd4, 16'h0080, 32'h0040_0040},
        '{3'd4, 16'h0100, 32'h0000_0040}};
    logic [8:0]  fidx [4] = '{omdsf_pkg::IDX_ALARM_LOW,
        omdsf_pkg::IDX_ALARM_RX, omdsf_pkg::IDX_WARN_LOW,
        omdsf_pkg::IDX_WARN_RX};

    omdsf_top dut (
        .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .TX_OFF_PIN(TX_OFF_PIN),
        .RATE_SEL_PIN(RATE_SEL_PIN), .LASER_FAULT_IN(LASER_FAULT_IN),
        .RX_SIGNAL_LOST_IN(RX_SIGNAL_LOST_IN), .VALUES_READY(VALUES_READY),
        .TEMP_VALUE(vals[0]), .SUPPLY_VALUE(vals[1]), .BIAS_VALUE(vals[2]),
        .TX_POWER_VALUE(vals[3]), .RX_POWER_VALUE(vals[4]), .TX_OFF(TX_OFF),
        .FULL_BW(FULL_BW), .TX_FAULT(TX_FAULT), .SIGNAL_LOSS(SIGNAL_LOSS),
        .IRQ(IRQ));

    omdsf_sense_model sense (
        .clk(MCLK), .rst(RST), .ready_cmd(ready_cmd), .fault_cmd(fault_cmd),
        .loss_cmd(loss_cmd), .sel(sel), .level(level),
        .values_ready(VALUES_READY), .laser_fault(LASER_FAULT_IN),
        .signal_lost(RX_SIGNAL_LOST_IN), .value(vals));

    // Free-running 50 MHz clock.
    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end

    function automatic logic [11:0] adr(input logic [8:0] i);
        return {1'b0, i, 2'b00};
    endfunction

    // Counts one comparison and reports a mismatch at once.
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // One APB transfer; the request holds until ready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge MCLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge MCLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wr(input logic [8:0] i, input logic [31:0] d);
        apb(1'b1, adr(i), d);
        chk(32'(err), 32'h0000_0000);
    endtask

    task automatic rchk(input logic [8:0] i, input logic [31:0] e);
        apb(1'b0, adr(i), 32'h0000_0000);
        chk(rd, e);
    endtask

    task automatic finish_test;
        $display("mismatches %0d of %0d checks", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge MCLK);
        fails++;
        finish_test();
    end

    // Table of flag cases, then hand-written cases.
    initial begin
        {PSEL, PENABLE, PWRITE, TX_OFF_PIN, RATE_SEL_PIN} = 5'b0_0000;
        {ready_cmd, fault_cmd, loss_cmd} = 3'b000;
        PADDR = 12'h000;
        PWDATA = 32'h0000_0000;
        sel = 3'd7;
        level = 16'h0000;
        RST = 1'b1;
        repeat (20) @(posedge MCLK);
        chk(32'({TX_OFF, FULL_BW, IRQ, PREADY}), 32'h0000_000c);
        RST <= 1'b0;
        rchk(omdsf_pkg::IDX_STATUS_CTRL, 32'h0000_0001);
        for (int q = 0; q < 5; q++) begin
            wr(9'(4 * q), 32'h0000_1000);
            wr(9'(4 * q + 1), q == 0 ? 32'h0000_ff00 : 32'h0000_0100);
            wr(9'(4 * q + 2), 32'h0000_0c00);
            wr(9'(4 * q + 3), q == 0 ? 32'h0000_ff80 : 32'h0000_0200);
        end
        ready_cmd <= 1'b1;
        rchk(omdsf_pkg::IDX_STATUS_CTRL, 32'h0000_0000);
        for (int k = 0; k < 13; k++) begin
            sel <= rows[k].sel;
            level <= rows[k].lvl;
            repeat (4) @(posedge MCLK);
            for (int b = 0; b < 4; b++) begin
                apb(1'b0, adr(fidx[b]), 32'h0000_0000);
                f = {f[23:0], rd[7:0]};
            end
            chk(f, rows[k].flags);
            chk(32'(IRQ), 32'h0000_0000);
        end
        sel <= 3'd7;
        rchk(omdsf_pkg::IDX_IRQ_STATUS, 32'h000f_ffff);
        wr(omdsf_pkg::IDX_IRQ_MASK, 32'h0000_0001);
        repeat (3) @(posedge MCLK);
        chk(32'(IRQ), 32'h0000_0001);
        wr(omdsf_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
        repeat (3) @(posedge MCLK);
        chk(32'(IRQ), 32'h0000_0000);
        rchk(omdsf_pkg::IDX_IRQ_STATUS, 32'h000f_fffe);
        {TX_OFF_PIN, RATE_SEL_PIN, fault_cmd, loss_cmd} <= 4'hf;
        repeat (6) @(posedge MCLK);
        rchk(omdsf_pkg::IDX_STATUS_CTRL, 32'h0000_0096);
        chk(32'({TX_OFF, FULL_BW, TX_FAULT, SIGNAL_LOSS}),
            32'h0000_000f);
        {TX_OFF_PIN, RATE_SEL_PIN, fault_cmd, loss_cmd} <= 4'h0;
        repeat (6) @(posedge MCLK);
        chk(32'({TX_OFF, FULL_BW, TX_FAULT, SIGNAL_LOSS}),
            32'h0000_0004);
        wr(omdsf_pkg::IDX_STATUS_CTRL, 32'h0000_00ff);
        rchk(omdsf_pkg::IDX_STATUS_CTRL, 32'h0000_0040);
        chk(32'(TX_OFF), 32'h0000_0001);
        wr(omdsf_pkg::IDX_STATUS_CTRL, 32'h0000_0000);
        repeat (2) @(posedge MCLK);
        chk(32'(TX_OFF), 32'h0000_0000);
        wr(omdsf_pkg::IDX_ALARM_LOW, 32'h0000_00ff);
        rchk(omdsf_pkg::IDX_ALARM_LOW, 32'h0000_0000);
        wr(omdsf_pkg::IDX_USER_FIRST, 32'h0000_005a);
        wr(omdsf_pkg::IDX_USER_LAST, 32'h0000_00a5);
        rchk(omdsf_pkg::IDX_USER_FIRST, 32'h0000_005a);
        rchk(omdsf_pkg::IDX_USER_LAST, 32'h0000_00a5);
        wr(omdsf_pkg::IDX_LEGACY, 32'h0000_00ff);
        rchk(omdsf_pkg::IDX_LEGACY, 32'h0000_0000);
        apb(1'b0, adr(9'h0f8), 32'h0000_0000);
        chk({rd[30:0], err}, 32'h0000_0001);
        apb(1'b1, 12'h1b9, 32'h0000_00ff);
        chk(32'(err), 32'h0000_0001);
        RST <= 1'b1;
        repeat (3) @(posedge MCLK);
        chk(32'({TX_OFF, FULL_BW, IRQ, PREADY}), 32'h0000_000c);
        RST <= 1'b0;
        rchk(omdsf_pkg::IDX_USER_FIRST, 32'h0000_0000);
        rchk(omdsf_pkg::IDX_IRQ_MASK, 32'h0000_0000);
        finish_test();
    end
endmodule
